// File: hw/tmr2_top.sv
// Timer-two core: capture, auto-reload up/down, baud tick and clock-out.
// Assumes an APB master on i_mclk; trigger and count pins are asynchronous.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module tmr2_top
  import tmr2_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // Pins
  input wire logic i_trigger_pin,
  input wire logic i_clock_out_port_pin,
  output logic o_clock_out_port_pin,
  output logic o_clock_out_port_pin_oe,
  // Status
  output logic o_irq,
  output logic o_baud_tick
);

  typedef struct packed {
    tmr2_ctrl_s ctrl;
    tmr2_moder_s moder;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic irq_en;
    logic [3:0] pre;
    logic cko;
    logic cko_oe;
    logic irq;
    logic baud_tick;
    tmr2_apb_rsp_s rsp;
  } tmr2_state_s;

  tmr2_state_s st_reg;
  tmr2_state_s st_next;

  logic trig_lvl;
  logic trig_fall;
  logic cin_fall;

  tmr2_sync u_trig_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(i_trigger_pin),
    .o_level(trig_lvl),
    .o_fall(trig_fall)
  );

  tmr2_sync u_cin_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(i_clock_out_port_pin),
    .o_level(),
    .o_fall(cin_fall)
  );

  tmr2_apb_req_s req;
  assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                 paddr: i_paddr, pwdata: i_pwdata};

  tmr2_mode_e mode;
  logic baud;
  logic cko_on;
  logic tick;
  logic ext_evt;
  logic roll_up;
  logic roll_dn;
  logic count_down;
  logic wr;
  logic rd;
  logic [3:0] div;
  logic ovf_set;
  logic ext_set;
  logic ext_tgl;

  always_comb begin
    baud = st_reg.ctrl.rx_clk_sel | st_reg.ctrl.tx_clk_sel;
    // Clock-out may run beside baud generation
    cko_on = st_reg.moder.clk_oe & ~st_reg.ctrl.reload_sel & ~st_reg.ctrl.tc_sel;
    if (baud) begin
      mode = TMR2_M_BAUD;
    end else if (cko_on) begin
      mode = TMR2_M_CLKOUT;
    end else if (st_reg.ctrl.reload_sel) begin
      mode = TMR2_M_CAPTURE;
    end else begin
      mode = TMR2_M_RELOAD;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.baud_tick = 1'b0;
    wr = req.psel & req.penable & req.pwrite;
    rd = req.psel & ~req.penable & ~req.pwrite;
    ovf_set = 1'b0;
    ext_set = 1'b0;
    ext_tgl = 1'b0;
    roll_up = 1'b0;
    roll_dn = 1'b0;
    tick = 1'b0;
    // Prescaler picks osc/12, osc/2 for baud or clock-out
    if (baud) begin
      div = TMR2_DIV_BAUD;
    end else if (cko_on) begin
      div = TMR2_DIV_CLKOUT;
    end else begin
      div = TMR2_DIV_TIMER;
    end
    if (st_reg.ctrl.run) begin
      if (st_reg.ctrl.tc_sel) begin
        tick = cin_fall;
      end else if (st_reg.pre >= div - 4'h1) begin
        tick = 1'b1;
        st_next.pre = 4'h0;
      end else begin
        st_next.pre = st_reg.pre + 4'h1;
      end
    end
    count_down = st_reg.moder.down_count_enable & ~trig_lvl & (mode == TMR2_M_RELOAD);
    ext_evt = trig_fall & st_reg.ctrl.ext_en & ~baud;
    if (tick) begin
      if (count_down) begin
        if (st_reg.cnt == st_reg.rcap) begin
          roll_dn = 1'b1;
          st_next.cnt = TMR2_CNT_MAX;
        end else begin
          st_next.cnt = st_reg.cnt - 16'h0001;
        end
      end else if (st_reg.cnt == TMR2_CNT_MAX) begin
        roll_up = 1'b1;
        if (mode == TMR2_M_CAPTURE) begin
          st_next.cnt = 16'h0000;
        end else begin
          st_next.cnt = st_reg.rcap;
        end
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
    end
    if (roll_up || roll_dn) begin
      if (baud) begin
        st_next.baud_tick = 1'b1;
      end else if (!cko_on) begin
        ovf_set = 1'b1;
      end
      if (cko_on) begin
        st_next.cko = ~st_reg.cko;
      end
      if (st_reg.moder.down_count_enable && mode == TMR2_M_RELOAD) begin
        ext_tgl = 1'b1;
      end
    end
    if (ext_evt && !(st_reg.moder.down_count_enable && mode == TMR2_M_RELOAD)) begin
      if (mode == TMR2_M_CAPTURE) begin
        st_next.rcap = st_reg.cnt;
        ext_set = 1'b1;
      end else if (mode == TMR2_M_RELOAD) begin
        st_next.cnt = st_reg.rcap;
        ext_set = 1'b1;
      end
    end
    st_next.cko_oe = cko_on;
    // APB: one wait-free access phase
    st_next.rsp.pready = 1'b1;
    st_next.rsp.pslverr = 1'b0;
    if (rd) begin
      case (req.paddr)
        TMR2_CTRL_ADDR: st_next.rsp.prdata = {24'h000000, st_reg.ctrl};
        TMR2_MODE_ADDR: st_next.rsp.prdata = {30'h0, st_reg.moder};
        TMR2_CNT_ADDR: st_next.rsp.prdata = {16'h0000, st_reg.cnt};
        TMR2_RCAP_ADDR: st_next.rsp.prdata = {16'h0000, st_reg.rcap};
        TMR2_IE_ADDR: st_next.rsp.prdata = {31'h0, st_reg.irq_en};
        default: st_next.rsp.prdata = 32'h00000000;
      endcase
      st_next.rsp.pslverr = !(req.paddr inside {TMR2_CTRL_ADDR, TMR2_MODE_ADDR,
                              TMR2_CNT_ADDR, TMR2_RCAP_ADDR, TMR2_IE_ADDR});
    end else if (req.psel && !req.penable) begin
      st_next.rsp.prdata = 32'h00000000;
      st_next.rsp.pslverr = !(req.paddr inside {TMR2_CTRL_ADDR, TMR2_MODE_ADDR,
                              TMR2_CNT_ADDR, TMR2_RCAP_ADDR, TMR2_IE_ADDR});
    end
    if (wr) begin
      case (req.paddr)
        TMR2_CTRL_ADDR: begin
          st_next.ctrl = tmr2_ctrl_s'(req.pwdata[7:0]);
        end
        TMR2_MODE_ADDR: begin
          st_next.moder = tmr2_moder_s'(req.pwdata[1:0]);
        end
        TMR2_CNT_ADDR: begin
          st_next.cnt = req.pwdata[15:0];
        end
        TMR2_RCAP_ADDR: begin
          st_next.rcap = req.pwdata[15:0];
        end
        TMR2_IE_ADDR: begin
          st_next.irq_en = req.pwdata[0];
        end
        default: begin
          st_next.irq_en = st_reg.irq_en;
        end
      endcase
    end
    // Hardware set or toggle wins over a software write
    if (ovf_set) begin
      st_next.ctrl.ovf_flag = 1'b1;
    end
    if (ext_set) begin
      st_next.ctrl.ext_flag = 1'b1;
    end
    if (ext_tgl) begin
      st_next.ctrl.ext_flag = ~st_reg.ctrl.ext_flag;
    end
    // Interrupt: overflow flag, or external flag outside down-count mode
    st_next.irq = st_next.irq_en & (st_next.ctrl.ovf_flag |
                  (st_next.ctrl.ext_flag & ~st_next.moder.down_count_enable));
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_pready = st_reg.rsp.pready;
  assign o_pslverr = st_reg.rsp.pslverr;
  assign o_prdata = st_reg.rsp.prdata;
  assign o_clock_out_port_pin = st_reg.cko;
  assign o_clock_out_port_pin_oe = st_reg.cko_oe;
  assign o_irq = st_reg.irq;
  assign o_baud_tick = st_reg.baud_tick;

endmodule : tmr2_top

// File: hw/tmr2_pkg.sv
// Constants, register map and state carriers for the timer-two block.
// Assumes an APB master on i_mclk and pins brought in from outside the clock domain.
// What this block does
// - Capture mode, external enable: trigger fall copies count bytes into reload/capture.
// - Capture mode trigger fall also sets external flag, which can interrupt.
// - Down-count enable resets to zero; when set in reload mode, trigger pin level sets direction.
// - Up-only reload mode: count to FFFF, overflow sets flag, loads reload value.
// - Up-only with external enable: trigger fall reloads and sets external flag.
// - Up-only reload: overflow or external flag requests interrupt when enabled.
// - Down-count enabled, trigger high: count up, overflow at FFFF, set flag, reload.
// - Down-count, trigger low: count down, underflow at reload value, set flag, load FFFF.
// - Down-count enabled: external flag toggles per over/underflow, no interrupt.
// - Receive or transmit clock select set enters baud-rate generator mode.
// - Clock-out pin: 50% duty, osc divided by four times (65536 minus reload).
// - Clock-out rollovers request no interrupt, as in baud-rate mode.
// - Baud generation and clock-out run together from the shared reload value.
// - Clock-out port pin doubles as external count input in counter operation.
// - Run bit starts timer when one, stops it when zero.
// - Counter select: clear counts osc/12 (osc/2 baud or clock-out), set counts input falls.
// - Overflow flag set by overflow, cleared by software, never set in baud mode.
// - External enable clear: trigger transitions ignored for capture and reload.
package tmr2_pkg;

  // Register byte addresses
  localparam logic [11:0] TMR2_CTRL_ADDR = 12'h000;
  localparam logic [11:0] TMR2_MODE_ADDR = 12'h004;
  localparam logic [11:0] TMR2_CNT_ADDR = 12'h008;
  localparam logic [11:0] TMR2_RCAP_ADDR = 12'h00C;
  localparam logic [11:0] TMR2_IE_ADDR = 12'h010;

  // Control register bit positions
  localparam int TMR2_B_RELOAD_SEL = 0;
  localparam int TMR2_B_TC_SEL = 1;
  localparam int TMR2_B_RUN = 2;
  localparam int TMR2_B_EXT_EN = 3;
  localparam int TMR2_B_TX_CLK = 4;
  localparam int TMR2_B_RX_CLK = 5;
  localparam int TMR2_B_EXT_FLAG = 6;
  localparam int TMR2_B_OVF_FLAG = 7;
  // Mode register bit positions
  localparam int TMR2_B_DOWN_COUNT_ENABLE = 0;
  localparam int TMR2_B_CLK_OE = 1;

  // Reset values and maximum count
  localparam logic [7:0] TMR2_CTRL_RST = 8'h00;
  localparam logic [1:0] TMR2_MODE_RST = 2'h0;
  localparam logic [15:0] TMR2_CNT_RST = 16'h0000;
  localparam logic [15:0] TMR2_RCAP_RST = 16'h0000;
  localparam logic [15:0] TMR2_CNT_MAX = 16'hFFFF;

  // Prescale counts in core clocks
  localparam logic [3:0] TMR2_DIV_TIMER = 4'hC;
  localparam logic [3:0] TMR2_DIV_BAUD = 4'h2;
  localparam logic [3:0] TMR2_DIV_CLKOUT = 4'h2;

  typedef enum logic [1:0] {
    TMR2_M_RELOAD = 2'b00,
    TMR2_M_CAPTURE = 2'b01,
    TMR2_M_BAUD = 2'b10,
    TMR2_M_CLKOUT = 2'b11
  } tmr2_mode_e;

  typedef struct packed {
    logic ovf_flag;
    logic ext_flag;
    logic rx_clk_sel;
    logic tx_clk_sel;
    logic ext_en;
    logic run;
    logic tc_sel;
    logic reload_sel;
  } tmr2_ctrl_s;

  typedef struct packed {
    logic clk_oe;
    logic down_count_enable;
  } tmr2_moder_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tmr2_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmr2_apb_rsp_s;

endpackage : tmr2_pkg

// File: hw/tmr2_sync.sv
// Two-flop synchroniser with previous-sample falling edge detect.
// Assumes an asynchronous pin input and a clock enable that freezes it.
`timescale 1ns/1ns
module tmr2_sync
  import tmr2_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Pin
  input wire logic i_pin,
  // Result
  output logic o_level,
  output logic o_fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tmr2_sync_s;

  tmr2_sync_s st_reg;
  tmr2_sync_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= 3'b111;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_level = st_reg.s2;
  assign o_fall = st_reg.s3 & ~st_reg.s2;

endmodule : tmr2_sync

// File: verif/tmr2_props.sv
// Port checker for the timer-two block.
// Assumes a single i_mclk domain and an APB master that keeps its request.
`timescale 1ns/1ns
module tmr2_props
  import tmr2_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  // Pins and status
  input wire logic i_trigger_pin,
  input wire logic i_clock_out_port_pin,
  input wire logic o_clock_out_port_pin,
  input wire logic o_clock_out_port_pin_oe,
  input wire logic o_irq,
  input wire logic o_baud_tick
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic mapped;
  assign mapped = i_paddr inside {TMR2_CTRL_ADDR, TMR2_MODE_ADDR, TMR2_CNT_ADDR,
                                  TMR2_RCAP_ADDR, TMR2_IE_ADDR};
  sequence s_acc;
    i_psel && i_penable;
  endsequence
  sequence s_rd(logic [11:0] a);
    s_acc ##0 (!i_pwrite && i_paddr == a);
  endsequence
  property p_ready; $past(i_rst_b) |-> o_pready; endproperty
  property p_err; s_acc ##0 !mapped |-> o_pslverr; endproperty
  property p_noerr; s_acc ##0 mapped |-> !o_pslverr; endproperty
  property p_rd0; s_acc ##0 (!mapped && !i_pwrite) |-> o_prdata == 32'h0; endproperty
  property p_mode; s_rd(TMR2_MODE_ADDR) |-> o_prdata[31:2] == 30'h0; endproperty
  property p_cnt; s_rd(TMR2_CNT_ADDR) |-> o_prdata[31:16] == 16'h0; endproperty
  property p_half;
    o_clock_out_port_pin_oe && $changed(o_clock_out_port_pin)
      |=> $stable(o_clock_out_port_pin) || !o_clock_out_port_pin_oe;
  endproperty
  property p_tick; o_baud_tick |=> !o_baud_tick; endproperty
  property p_ieoff;
    s_acc ##0 (i_pwrite && i_paddr == TMR2_IE_ADDR && !i_pwdata[0]) |=> ##1 !o_irq;
  endproperty
  property p_tickirq; o_baud_tick |-> !$rose(o_irq); endproperty
  a_ready: assert property (p_ready) else $error("pready low after reset");
  a_err: assert property (p_err) else $error("no error on unmapped access");
  a_noerr: assert property (p_noerr) else $error("error on mapped access");
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  a_mode: assert property (p_mode) else $error("mode upper bits set");
  a_cnt: assert property (p_cnt) else $error("count wider than 16 bits");
  a_half: assert property (p_half) else $error("clock-out half period short");
  a_tick: assert property (p_tick) else $error("baud tick longer than one cycle");
  a_ieoff: assert property (p_ieoff) else $error("irq with enable cleared");
  a_tickirq: assert property (p_tickirq) else $error("irq from baud rollover");
endmodule : tmr2_props

bind tmr2_top tmr2_props tmr2_props_inst (.i_mclk, .i_rst_b, .i_ce, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_prdata, .i_trigger_pin,
  .i_clock_out_port_pin, .o_clock_out_port_pin, .o_clock_out_port_pin_oe, .o_irq,
  .o_baud_tick);

// File: verif/tmr2_pins_model.sv
// Far side of the trigger pin and the shared clock-out port pin.
// Assumes bench level requests; the port pin is pulled up when undriven.
`timescale 1ns/1ns
module tmr2_pins_model (
  // Clock
  input wire logic i_mclk,
  // Bench controls
  input wire logic i_trig_lvl,
  input wire logic i_cnt_run,
  // Device side of the port pin
  input wire logic i_pin_drv,
  input wire logic i_pin_oe,
  // Pin levels
  output logic o_trigger_pin,
  output logic o_pin_wire
);
  logic [1:0] div_reg = 2'h0;
  logic trig_reg = 1'b1;
  always @(posedge i_mclk) begin
    trig_reg <= i_trig_lvl;
    div_reg <= div_reg + 2'h1;
  end
  assign o_trigger_pin = trig_reg;
  // Device wins when enabled, else count source or pull-up
  assign o_pin_wire = i_pin_oe ? i_pin_drv : (i_cnt_run ? div_reg[1] : 1'b1);
endmodule : tmr2_pins_model

// File: verif/timer_two_capture_reload_clockout_tb.sv
// Self-checking bench for the timer-two block.
// Assumes tmr2_top with APB always ready and the pin model on its far side.
`timescale 1ns/1ns
module timer_two_capture_reload_clockout_tb
  import tmr2_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} tmr2_row_s;
  localparam logic [11:0] CT = TMR2_CTRL_ADDR, MD = TMR2_MODE_ADDR, CN = TMR2_CNT_ADDR;
  localparam logic [11:0] RC = TMR2_RCAP_ADDR, IE = TMR2_IE_ADDR;
  localparam logic W = 1'b1, R = 1'b0;
  logic i_mclk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q, v;
  logic trig_lvl = 1'b1, cnt_run = 1'b0, err, o_pready, o_pslverr, i_trigger_pin;
  logic ce = 1'b1;
  logic i_clock_out_port_pin, o_clock_out_port_pin, o_clock_out_port_pin_oe, o_irq, o_baud_tick;
  int miscompares = 0, compares = 0, n;
  tmr2_row_s rows[7] = '{'{CT, 32'h0, 1'b0}, '{MD, 32'h0, 1'b0}, '{CN, 32'h0, 1'b0},
    '{RC, 32'h0, 1'b0}, '{IE, 32'h0, 1'b0}, '{12'h014, 32'h0, 1'b1}, '{12'hFFC, 32'h0, 1'b1}};
  tmr2_top tmr2_top_inst (.i_mclk, .i_rst_b, .i_ce(ce), .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_prdata, .i_trigger_pin,
    .i_clock_out_port_pin, .o_clock_out_port_pin, .o_clock_out_port_pin_oe, .o_irq,
    .o_baud_tick);
  tmr2_pins_model tmr2_pins_model_inst (.i_mclk, .i_trig_lvl(trig_lvl), .i_cnt_run(cnt_run),
    .i_pin_drv(o_clock_out_port_pin), .i_pin_oe(o_clock_out_port_pin_oe),
    .o_trigger_pin(i_trigger_pin), .o_pin_wire(i_clock_out_port_pin));
  initial forever #50 i_mclk = ~i_mclk;
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (o_pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask : bus
  task automatic wait_ctrl(input int b);
    int k;
    k = 0;
    do begin
      bus(R, CT, 32'h0);
      k++;
    end while (q[b] !== 1'b1 && k < 200);
    chk("flag", 32'h1, {31'h0, q[b]});
    if (k >= 200) finish_test();
  endtask : wait_ctrl
  task automatic wait_sig(ref logic s, input logic lv);
    int k;
    for (k = 0; k < 500 && s !== lv; k++) @(negedge i_mclk);
    if (s !== lv) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_sig
  task automatic fall;
    @(posedge i_mclk);
    trig_lvl <= 1'b0;
    repeat (6) @(posedge i_mclk);
    trig_lvl <= 1'b1;
    repeat (6) @(posedge i_mclk);
  endtask : fall
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    foreach (rows[i]) begin
      bus(R, rows[i].a, 32'h0);
      chk("reset value", rows[i].d, q);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, err});
    end
    bus(W, RC, 32'h0000FFF0);
    bus(W, CN, 32'h0000FFFC);
    bus(W, IE, 32'h1);
    bus(W, CT, 32'h4);
    wait_ctrl(TMR2_B_OVF_FLAG);
    chk("irq ovf", 32'h1, {31'h0, o_irq});
    bus(R, CN, 32'h0);
    chk("reload", 32'h0FFF, q >> 4);
    bus(W, CT, 32'h0);
    bus(R, CN, 32'h0);
    v = q;
    repeat (40) @(posedge i_mclk);
    bus(R, CN, 32'h0);
    chk("stopped", v, q);
    bus(W, RC, 32'h00001234);
    bus(W, CN, 32'h00000100);
    bus(W, CT, 32'h4);
    fall();
    bus(R, CT, 32'h0);
    chk("ext off", 32'h0, {31'h0, q[6]});
    bus(R, CN, 32'h0);
    chk("no reload", 32'h01, q >> 8);
    bus(W, CT, 32'hC);
    fall();
    bus(R, CT, 32'h0);
    chk("ext reload flag", 32'h1, {31'h0, q[6]});
    bus(R, CN, 32'h0);
    chk("ext reload", 32'h12, q >> 8);
    bus(W, CN, 32'h00005000);
    bus(W, CT, 32'hD);
    fall();
    bus(R, RC, 32'h0);
    chk("capture", 32'h50, q >> 8);
    bus(R, CT, 32'h0);
    chk("capture flag", 32'h1, {31'h0, q[6]});
    bus(W, CT, 32'h0);
    trig_lvl <= 1'b0;
    bus(W, MD, 32'h1);
    bus(W, RC, 32'h00000010);
    bus(W, CN, 32'h00000013);
    bus(W, CT, 32'h4);
    wait_ctrl(TMR2_B_OVF_FLAG);
    chk("toggle up", 32'h1, {31'h0, q[6]});
    bus(R, CN, 32'h0);
    chk("underflow", 32'hFF, q >> 8);
    bus(W, CT, 32'h44);
    repeat (3) @(posedge i_mclk);
    chk("ext no irq", 32'h0, {31'h0, o_irq});
    trig_lvl <= 1'b1;
    wait_ctrl(TMR2_B_OVF_FLAG);
    chk("toggle down", 32'h0, {31'h0, q[6]});
    bus(R, CN, 32'h0);
    chk("up reload", 32'h00, q >> 8);
    bus(W, RC, 32'h0000FFFE);
    bus(W, CN, 32'h0000FFFE);
    bus(W, MD, 32'h2);
    bus(W, CT, 32'h4);
    wait_sig(o_clock_out_port_pin_oe, 1'b1);
    wait_sig(o_clock_out_port_pin, 1'b0);
    wait_sig(o_clock_out_port_pin, 1'b1);
    for (n = 0; n < 100 && o_clock_out_port_pin === 1'b1; n++) @(negedge i_mclk);
    chk("half period", 32'h4, n);
    chk("clkout irq", 32'h0, {31'h0, o_irq});
    bus(W, CT, 32'h14);
    wait_sig(o_baud_tick, 1'b1);
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_baud_tick !== 1'b1 && n < 100);
    chk("tick gap", 32'h4, n);
    chk("both run", 32'h1, {31'h0, o_clock_out_port_pin_oe});
    wait_sig(o_clock_out_port_pin, 1'b0);
    wait_sig(o_clock_out_port_pin, 1'b1);
    for (n = 0; n < 100 && o_clock_out_port_pin === 1'b1; n++) @(negedge i_mclk);
    chk("baud half period", 32'h4, n);
    bus(R, CT, 32'h0);
    chk("baud ovf", 32'h0, {31'h0, q[7]});
    // Mid-run reset
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk("reset oe", 32'h0, {31'h0, o_clock_out_port_pin_oe});
    chk("reset tick", 32'h0, {31'h0, o_baud_tick});
    i_rst_b <= 1'b1;
    bus(R, MD, 32'h0);
    chk("reset mode", 32'h0, q);
    cnt_run <= 1'b1;
    bus(W, CT, 32'h6);
    repeat (40) @(posedge i_mclk);
    bus(W, CT, 32'h0);
    cnt_run <= 1'b0;
    bus(R, CN, 32'h0);
    chk("pin count", 32'h1, {31'h0, q >= 32'h8 && q <= 32'hD});
    // Clock enable low freezes the count
    bus(W, CT, 32'h4);
    bus(R, CN, 32'h0);
    v = q;
    ce <= 1'b0;
    repeat (60) @(posedge i_mclk);
    ce <= 1'b1;
    bus(R, CN, 32'h0);
    chk("frozen", 32'h1, {31'h0, (q - v) <= 32'h1});
    // Software-set flag, interrupt enable toggled
    bus(W, CT, 32'h80);
    bus(W, IE, 32'h1);
    repeat (2) @(posedge i_mclk);
    chk("irq sw flag", 32'h1, {31'h0, o_irq});
    bus(W, IE, 32'h0);
    repeat (2) @(posedge i_mclk);
    chk("irq off", 32'h0, {31'h0, o_irq});
    finish_test();
  end
endmodule : timer_two_capture_reload_clockout_tb
